// ### rtl/afr_pkg.sv
// constants and pin tables for the alternate-function router
package afr_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PORT_CNT = 7;
  localparam int unsigned PINS_PER_PORT = 16;
  localparam int unsigned PIN_CNT = PORT_CNT * PINS_PER_PORT;
  localparam int unsigned PIN_IDX_W = 7;

  // register byte offsets
  localparam logic [ADDR_W-1:0] EVENT_OUTPUT_CONTROL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] PERIPHERAL_REMAP_ONE_OFS = 8'h04;

  // event_output_control fields
  localparam int unsigned EV_PIN_LSB = 0;
  localparam int unsigned EV_PIN_W = 4;
  localparam int unsigned EV_PORT_LSB = 4;
  localparam int unsigned EV_PORT_W = 3;
  localparam int unsigned EV_EN_BIT = 7;
  localparam int unsigned EV_CTRL_W = 8;
  localparam logic [EV_CTRL_W-1:0] EV_CTRL_RST = 8'h00;
  localparam logic [EV_PORT_W-1:0] EV_PORT_RESERVED = 3'h7;

  // peripheral_remap_one fields
  localparam int unsigned SERIAL_PERIPH_ONE_REMAP_BIT = 0;
  localparam int unsigned TWO_WIRE_ONE_REMAP_BIT = 1;
  localparam int unsigned SERIAL_ONE_REMAP_BIT = 2;
  localparam int unsigned REMAP_W = 3;
  localparam logic [REMAP_W-1:0] REMAP_RST = 3'h0;

  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;

  function automatic logic [PIN_IDX_W-1:0] afr_pin_idx(input logic [2:0] port,
                                                      input logic [3:0] pin);
    afr_pin_idx = {port, pin};
  endfunction : afr_pin_idx

  // serial peripheral order: chip select, clock, master-in, master-out
  localparam logic [PIN_IDX_W-1:0] SPI_DEF_PIN [4] = '{7'h04, 7'h05, 7'h06, 7'h07};
  localparam logic [PIN_IDX_W-1:0] SPI_ALT_PIN [4] = '{7'h0f, 7'h13, 7'h14, 7'h15};
  // two-wire order: clock, data
  localparam logic [PIN_IDX_W-1:0] TWI_DEF_PIN [2] = '{7'h16, 7'h17};
  localparam logic [PIN_IDX_W-1:0] TWI_ALT_PIN [2] = '{7'h18, 7'h19};
  // serial order: transmit, receive
  localparam logic [PIN_IDX_W-1:0] UART_DEF_PIN [2] = '{7'h09, 7'h0a};
  localparam logic [PIN_IDX_W-1:0] UART_ALT_PIN [2] = '{7'h16, 7'h17};
endpackage : afr_pkg

// ### rtl/afr_periph_if.sv
// peripheral signal bundle between router top and the remap mux
`timescale 1ns/1ps
`default_nettype none
interface afr_periph_if;
  logic spi_en;
  logic [3:0] spi_o;
  logic [3:0] spi_oe;
  logic [3:0] spi_i;
  logic twi_en;
  logic [1:0] twi_low;
  logic [1:0] twi_i;
  logic uart_en;
  logic uart_tx;
  logic uart_rx;

  modport mux (
    input spi_en, spi_o, spi_oe, twi_en, twi_low, uart_en, uart_tx,
    output spi_i, twi_i, uart_rx
  );
  modport periph (
    output spi_en, spi_o, spi_oe, twi_en, twi_low, uart_en, uart_tx,
    input spi_i, twi_i, uart_rx
  );
endinterface : afr_periph_if
`default_nettype wire

// ### rtl/afr_remap_mux.sv
// remap-driven routing of peripheral signals onto pins
`timescale 1ns/1ps
`default_nettype none
module afr_remap_mux
  import afr_pkg::*;
(
  input wire logic [REMAP_W-1:0] remap, // remap register bits
  afr_periph_if.mux per, // peripheral side
  input wire logic [PIN_CNT-1:0] pin_in_s, // synchronised pin levels
  output logic [PIN_CNT-1:0] af_out, // alternate output level
  output logic [PIN_CNT-1:0] af_oe, // alternate output enable
  output logic [PIN_CNT-1:0] af_own // pin taken by a peripheral
);
  logic [PIN_IDX_W-1:0] p;

  always_comb begin
    p = '0;
    af_out = '0;
    af_oe = '0;
    af_own = '0;
    per.spi_i = '0;
    per.twi_i = 2'b11;
    per.uart_rx = 1'b1;
    for (int i = 0; i < 4; i++) begin
      p = remap[SERIAL_PERIPH_ONE_REMAP_BIT] ? SPI_ALT_PIN[i] : SPI_DEF_PIN[i];
      if (per.spi_en) begin
        af_own[p] = 1'b1;
        af_out[p] = per.spi_o[i];
        af_oe[p] = per.spi_oe[i];
        per.spi_i[i] = pin_in_s[p];
      end
    end
    for (int i = 0; i < 2; i++) begin
      p = remap[TWO_WIRE_ONE_REMAP_BIT] ? TWI_ALT_PIN[i] : TWI_DEF_PIN[i];
      if (per.twi_en) begin
        // open drain: only ever pulls low
        af_own[p] = 1'b1;
        af_out[p] = 1'b0;
        af_oe[p] = per.twi_low[i];
        per.twi_i[i] = pin_in_s[p];
      end
    end
    p = remap[SERIAL_ONE_REMAP_BIT] ? UART_ALT_PIN[0] : UART_DEF_PIN[0];
    if (per.uart_en) begin
      af_own[p] = 1'b1;
      af_out[p] = per.uart_tx;
      af_oe[p] = 1'b1;
    end
    p = remap[SERIAL_ONE_REMAP_BIT] ? UART_ALT_PIN[1] : UART_DEF_PIN[1];
    if (per.uart_en) begin
      af_own[p] = 1'b1;
      per.uart_rx = pin_in_s[p];
    end
  end
endmodule : afr_remap_mux
`default_nettype wire

// ### rtl/afr_top.sv
// alternate-function router: event output routing and peripheral pin remap
`timescale 1ns/1ps
`default_nettype none
module afr_top
  import afr_pkg::*;
(
  input wire logic ref_clk, // peripheral clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic blk_clk_en, // block bit of peripheral_clock_enable_reg
  input wire logic psel, // bus select
  input wire logic penable, // bus access phase
  input wire logic pwrite, // bus write
  input wire logic [ADDR_W-1:0] paddr, // bus byte address
  input wire logic [DATA_W-1:0] pwdata, // bus write data
  output logic [DATA_W-1:0] prdata, // bus read data
  output logic pready, // bus ready
  output logic pslverr, // bus error on unmapped offset
  input wire logic core_event_signal, // event pulse from the core
  input wire logic spi_en, // serial peripheral one enabled
  input wire logic [3:0] spi_o, // spi outputs: cs, clk, miso, mosi
  input wire logic [3:0] spi_oe, // spi output enables
  output logic [3:0] spi_i, // spi pin levels back
  input wire logic twi_en, // two-wire one enabled
  input wire logic [1:0] twi_low, // two-wire pull low: clk, data
  output logic [1:0] twi_i, // two-wire pin levels back
  input wire logic uart_en, // serial one enabled
  input wire logic uart_tx, // serial one transmit
  output logic uart_rx, // serial one receive
  input wire logic [PIN_CNT-1:0] gpio_out, // port output levels
  input wire logic [PIN_CNT-1:0] gpio_oe, // port output enables
  input wire logic [PIN_CNT-1:0] pin_in, // pad input levels
  output logic [PIN_CNT-1:0] pin_out, // pad output level
  output logic [PIN_CNT-1:0] pin_oe, // pad output enable
  output logic [PIN_CNT-1:0] pin_alt // pad under alternate function
);
  logic [EV_CTRL_W-1:0] ev_ctrl_q;
  logic [REMAP_W-1:0] remap_q;
  logic [DATA_W-1:0] prdata_q;
  logic [PIN_CNT-1:0] pin_meta_q;
  logic [PIN_CNT-1:0] pin_sync_q;
  logic [PIN_CNT-1:0] pin_out_q;
  logic [PIN_CNT-1:0] pin_oe_q;
  logic [PIN_CNT-1:0] pin_alt_q;
  logic [PIN_CNT-1:0] af_out;
  logic [PIN_CNT-1:0] af_oe;
  logic [PIN_CNT-1:0] af_own;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  logic ev_route;
  logic [PIN_IDX_W-1:0] ev_idx;

  afr_periph_if per ();

  function automatic logic [DATA_W-1:0] afr_read(input logic [ADDR_W-1:0] a,
                                                 input logic [EV_CTRL_W-1:0] ev,
                                                 input logic [REMAP_W-1:0] rm);
    afr_read = '0;
    if (a == EVENT_OUTPUT_CONTROL_OFS) begin
      afr_read = {{(DATA_W-EV_CTRL_W){1'b0}}, ev};
    end else if (a == PERIPHERAL_REMAP_ONE_OFS) begin
      afr_read = {{(DATA_W-REMAP_W){1'b0}}, rm};
    end
  endfunction : afr_read

  // bus decode; no byte lanes exist, every access is a whole word
  assign addr_hit = (paddr == EVENT_OUTPUT_CONTROL_OFS) || (paddr == PERIPHERAL_REMAP_ONE_OFS);
  assign wr_en = psel && penable && pwrite && blk_clk_en;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = prdata_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_ctrl_q <= EV_CTRL_RST;
    end else if (wr_en && paddr == EVENT_OUTPUT_CONTROL_OFS) begin
      ev_ctrl_q <= pwdata[EV_CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      remap_q <= REMAP_RST;
    end else if (wr_en && paddr == PERIPHERAL_REMAP_ONE_OFS) begin
      remap_q <= pwdata[REMAP_W-1:0];
    end
  end

  // read data captured in setup so it stands through the access phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      // with the block clock off the registers are unreachable and read zero
      prdata_q <= blk_clk_en ? afr_read(paddr, ev_ctrl_q, remap_q) : '0;
    end
  end

  // pads are asynchronous to ref_clk
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign per.spi_en = spi_en;
  assign per.spi_o = spi_o;
  assign per.spi_oe = spi_oe;
  assign per.twi_en = twi_en;
  assign per.twi_low = twi_low;
  assign per.uart_en = uart_en;
  assign per.uart_tx = uart_tx;
  assign spi_i = per.spi_i;
  assign twi_i = per.twi_i;
  assign uart_rx = per.uart_rx;

  afr_remap_mux u_mux (
    .remap(remap_q),
    .per(per.mux),
    .pin_in_s(pin_sync_q),
    .af_out(af_out),
    .af_oe(af_oe),
    .af_own(af_own)
  );

  // port code 7 is reserved and lands on no pin
  assign ev_route = ev_ctrl_q[EV_EN_BIT] &&
                    (ev_ctrl_q[EV_PORT_LSB +: EV_PORT_W] != EV_PORT_RESERVED);
  assign ev_idx = afr_pin_idx(ev_ctrl_q[EV_PORT_LSB +: EV_PORT_W],
                              ev_ctrl_q[EV_PIN_LSB +: EV_PIN_W]);

  // event output takes precedence over a peripheral sharing the same pin
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pin_alt_q <= '0;
    end else begin
      for (int i = 0; i < PIN_CNT; i++) begin
        if (ev_route && ev_idx == PIN_IDX_W'(i)) begin
          pin_out_q[i] <= core_event_signal;
          pin_oe_q[i] <= 1'b1;
          pin_alt_q[i] <= 1'b1;
        end else if (af_own[i]) begin
          pin_out_q[i] <= af_out[i];
          pin_oe_q[i] <= af_oe[i];
          pin_alt_q[i] <= 1'b1;
        end else begin
          pin_out_q[i] <= gpio_out[i];
          pin_oe_q[i] <= gpio_oe[i];
          pin_alt_q[i] <= 1'b0;
        end
      end
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_alt = pin_alt_q;
endmodule : afr_top
`default_nettype wire

// ### tb/afr_top_sva.sv
// port-level assertions for the alternate-function router
`timescale 1ns/1ps
`default_nettype none
module afr_top_sva
  import afr_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic blk_clk_en, // clock enable
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [ADDR_W-1:0] paddr, // address
  input wire logic [DATA_W-1:0] pwdata, // wdata
  input wire logic [DATA_W-1:0] prdata, // rdata
  input wire logic pslverr, // error
  input wire logic core_event_signal, // event
  input wire logic spi_en, // spi on
  input wire logic [3:0] spi_o, // spi out
  input wire logic [3:0] spi_oe, // spi oe
  input wire logic twi_en, // twi on
  input wire logic uart_en, // uart on
  input wire logic [PIN_CNT-1:0] gpio_out, // port out
  input wire logic [PIN_CNT-1:0] gpio_oe, // port oe
  input wire logic [PIN_CNT-1:0] pin_out, // pad out
  input wire logic [PIN_CNT-1:0] pin_oe, // pad oe
  input wire logic [PIN_CNT-1:0] pin_alt // pad alt
);
  // shadow copies, since the checker cannot see the registers
  logic [7:0] ev_q;
  logic [2:0] rm_q;
  logic wr_ok;
  logic quiet;
  logic rd_ok;
  assign wr_ok = psel && penable && pwrite && blk_clk_en;
  assign rd_ok = psel && penable && !pwrite && blk_clk_en;
  assign quiet = !spi_en && !twi_en && !uart_en;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) ev_q <= 8'h00;
    else if (wr_ok && paddr == 8'h00) ev_q <= pwdata[7:0];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rm_q <= 3'h0;
    else if (wr_ok && paddr == 8'h04) rm_q <= pwdata[2:0];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_ev; rd_ok && $past(blk_clk_en) && paddr == 8'h00 |-> prdata == {24'h0, ev_q}; endproperty
  a_rd_ev: assert property (p_rd_ev) else $error("event control readback wrong");
  property p_rd_rm; rd_ok && $past(blk_clk_en) && paddr == 8'h04 |-> prdata == {29'h0, rm_q}; endproperty
  a_rd_rm: assert property (p_rd_rm) else $error("remap readback wrong");
  property p_slverr; psel && penable && paddr != 8'h00 && paddr != 8'h04 |-> pslverr; endproperty
  a_slverr: assert property (p_slverr) else $error("no error on unmapped offset");
  property p_ev_pin; ev_q[7] && ev_q[6:4] != 3'h7 |=> pin_alt[$past(ev_q[6:0])] && pin_oe[$past(ev_q[6:0])] && pin_out[$past(ev_q[6:0])] == $past(core_event_signal); endproperty
  a_ev_pin: assert property (p_ev_pin) else $error("event not on chosen pin");
  property p_ev_rsv; ev_q[7] && ev_q[6:4] == 3'h7 && quiet |=> pin_alt == '0; endproperty
  a_ev_rsv: assert property (p_ev_rsv) else $error("reserved port drives a pin");
  property p_gpio; !ev_q[7] && quiet |=> pin_out == $past(gpio_out) && pin_oe == $past(gpio_oe) && pin_alt == '0; endproperty
  a_gpio: assert property (p_gpio) else $error("idle pins not on port logic");
  property p_spi_def; !ev_q[7] && spi_en && spi_oe[1] && !rm_q[0] |=> pin_oe[5] && pin_out[5] == $past(spi_o[1]); endproperty
  a_spi_def: assert property (p_spi_def) else $error("spi clock not on default pin");
  property p_spi_alt; !ev_q[7] && spi_en && spi_oe[1] && rm_q[0] |=> pin_oe[19] && pin_out[19] == $past(spi_o[1]) && !pin_alt[5]; endproperty
  a_spi_alt: assert property (p_spi_alt) else $error("spi clock not on alternate pin");
  c_ev: cover property (ev_q[7] && core_event_signal);
  c_rm: cover property (rm_q[0] && spi_en);
  c_err: cover property (psel && penable && pslverr);
endmodule : afr_top_sva
bind afr_top afr_top_sva u_sva (.ref_clk, .rst_n, .blk_clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .core_event_signal, .spi_en, .spi_o, .spi_oe, .twi_en, .uart_en,
  .gpio_out, .gpio_oe, .pin_out, .pin_oe, .pin_alt);
`default_nettype wire

// ### tb/afr_top_tb.sv
// self-checking bench for the alternate-function router
`timescale 1ns/1ps
`default_nettype none
module afr_top_tb;
  import afr_pkg::*;
  logic ref_clk = 1'b0, rst_n = 1'b0, blk_clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, core_event_signal = 1'b0, spi_en = 1'b0, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] spi_o = 4'ha, spi_oe = 4'hf;
  logic [PIN_CNT-1:0] gpio_out = {7{16'h5a3c}}, gpio_oe = {7{16'h0ff0}}, pin_out, pin_oe, pin_alt, ex;
  logic [PIN_CNT-1:0] pin_in = '0;
  logic [3:0] spi_i;
  logic [1:0] twi_i;
  logic uart_rx;
  int bad_count = 0, checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  afr_top dut (.ref_clk, .rst_n, .blk_clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_event_signal, .spi_en, .spi_o, .spi_oe, .spi_i, .twi_en(1'b0),
    .twi_low(2'b00), .twi_i, .uart_en(1'b0), .uart_tx(1'b1), .uart_rx, .gpio_out, .gpio_oe,
    .pin_in, .pin_out, .pin_oe, .pin_alt);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkp(input logic [PIN_CNT-1:0] got, input logic [PIN_CNT-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkp
  // one word per access, held until the ready edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    #1;
    while (pready !== 1'b1) begin
      n++;
      if (n > 8) begin
        bad_count++;
        stop_test();
      end
      @(posedge ref_clk);
      #1;
    end
    rd = prdata;
    err = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    chk({26'h0, spi_i, twi_i, 1'b0}, 32'h6);
    chk({31'h0, uart_rx}, 32'h1);
    settle();
    chkp(pin_out, gpio_out);
    $display("reset test done");
    bus(1'b1, 8'h00, 32'hffffffa5);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'ha5);
    core_event_signal <= 1'b1;
    settle();
    ex = gpio_out;
    ex[37] = 1'b1;
    chkp(pin_out, ex);
    core_event_signal <= 1'b0;
    settle();
    ex[37] = 1'b0;
    chkp(pin_out, ex);
    for (int p = 0; p < 7; p++) begin
      bus(1'b1, 8'h00, {24'h0, 1'b1, 3'(p), 4'hf});
      settle();
      ex = '0;
      ex[p*16+15] = 1'b1;
      chkp(pin_alt, ex);
    end
    bus(1'b1, 8'h00, 32'hff);
    settle();
    chkp(pin_alt, '0);
    // write with the block clock off must be lost
    blk_clk_en <= 1'b0;
    bus(1'b1, 8'h00, 32'h0);
    blk_clk_en <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hff);
    bus(1'b1, 8'h08, 32'h1);
    chk({31'h0, err}, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    $display("event test done");
    spi_en <= 1'b1;
    settle();
    ex = gpio_out;
    ex[7:4] = spi_o;
    chkp(pin_out, ex);
    bus(1'b1, 8'h04, 32'hffffffff);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h7);
    settle();
    ex = gpio_out;
    ex[15] = spi_o[0];
    ex[21:19] = spi_o[3:1];
    chkp(pin_out, ex);
    // master-in now on its alternate pin; two flops of sync before it shows
    pin_in[20] <= 1'b1;
    settle();
    chk({28'h0, spi_i}, 32'h4);
    pin_in <= '0;
    spi_en <= 1'b0;
    settle();
    chkp(pin_out, gpio_out);
    chkp(pin_oe, gpio_oe);
    $display("remap test done");
    stop_test();
  end
endmodule : afr_top_tb
`default_nettype wire
